/* File: verilog/spf_top.sv */
`timescale 1ns/10ps
// Function
// R1 - baud rate chosen from fixed set 50 to 115200, 9600 after reset
// R2 - character length is seven or eight data bits
// R3 - frames end with one or two stop bits
// R4 - parity odd, even, forced zero, forced one or none
// R5 - transmit side Xon/Xoff pacing enabled on its own
// R6 - receive side Xon/Xoff pacing enabled on its own
// R7 - RTS held low when off, high when on
// R8 - room mode: RTS high while receive buffer has room, low when full
// R9 - room mode: transmitter holds while CTS low; remote drops CTS
// R10 - DTR held low when off, high when on
// R11 - room mode: DTR high while receive buffer has room, low when full
// R12 - room mode: transmitter holds while DSR low; remote drops DSR
// R13 - DTR/DSR handshake unavailable when RS422 selected
// R14 - echo on retransmits each received character, off does not; Xon/Xoff under R5 and characters received while an echo waits are not echoed
// R15 - loop-back routes transmitter output to own receiver
// R16 - break condition can be sent on the serial output
// R17 - port reset reinitialises and flushes receive and transmit buffers
// R18 - frame: idle high, start low, data lsb first, parity, stop bits
// R19 - forced parity puts constant 0 or 1 regardless of data
// R20 - bit timing from system clock through programmable divider
module spf_top #(
  parameter int CLK_HZ   = spf_pkg::CLK_HZ,
  parameter int RX_DEPTH = 16
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // serial line
  input  wire logic        rxd,
  output logic             txd,
  // modem handshake
  input  wire logic        cts,
  input  wire logic        dsr,
  output logic             rts,
  output logic             dtr
);
  import spf_pkg::*;

  localparam int AW = $clog2(RX_DEPTH);

  typedef struct packed {
    logic [CTRL_W-1:0]             ctrl;
    logic                          wait_r;
    logic [31:0]                   rdata;
    spf_fr_t                       tst;
    logic [3:0]                    tdiv;
    logic [2:0]                    tbit;
    logic [7:0]                    tsh;
    logic                          tpar;
    logic                          tstop;
    logic                          line;
    logic                          txd;
    logic                          hold_v;
    logic [7:0]                    hold_d;
    logic                          echo_v;
    logic [7:0]                    echo_d;
    logic                          paused;
    logic                          xoff_sent;
    logic                          send_xoff;
    logic                          send_xon;
    spf_fr_t                       rst;
    logic [3:0]                    rdiv;
    logic [2:0]                    rbit;
    logic [7:0]                    rsh;
    logic                          rpar;
    logic [RX_DEPTH-1:0][7:0]      rbuf;
    logic [AW-1:0]                 wp;
    logic [AW-1:0]                 rp;
    logic [AW:0]                   cnt;
    logic                          perr;
    logic                          ferr;
    logic                          ovr;
    logic                          rts;
    logic                          dtr;
  } spf_st_t;

  spf_st_t    st_ff;
  spf_st_t    nxt_st;
  logic       tick;
  logic [31:0] bmask;

  // oversample enable for both directions
  spf_baud #(
    .CLK_HZ (CLK_HZ)
  ) u_baud (
    .clk  (clk),
    .rstn (rstn),
    .sel  (st_ff.ctrl[CF_BAUD +: 5]),
    .tick (tick)
  );

  // byte lane mask from the byte enables
  assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // control decode, next-state logic for bus, transmitter, receiver
  always_comb
  begin
    logic         word8;
    logic         stop2;
    spf_par_t     par;
    spf_hs_t      rts_m;
    spf_hs_t      dtr_m;
    logic         rx_in;
    logic         full;
    logic         hw_hold;
    logic         start;
    logic [7:0]   tdata;
    logic [7:0]   rdat;
    logic         push;
    logic         pop;
    logic         done;
    logic         pexp;
    logic         acc;
    nxt_st  = st_ff;
    word8   = st_ff.ctrl[CF_WORD8];
    stop2   = st_ff.ctrl[CF_STOP2];
    par     = spf_par_t'(st_ff.ctrl[CF_PAR +: 3]);
    rts_m   = spf_hs_t'(st_ff.ctrl[CF_RTS +: 2]);
    dtr_m   = st_ff.ctrl[CF_RS422] ? HS_OFF
            : spf_hs_t'(st_ff.ctrl[CF_DTR +: 2]);  // [R13]
    rx_in   = st_ff.ctrl[CF_LOOP] ? st_ff.line : rxd;  // [R15]
    full    = (st_ff.cnt == (AW+1)'(RX_DEPTH));
    hw_hold = (rts_m == HS_ROOM && !cts)    // [R9]
            || (dtr_m == HS_ROOM && !dsr);  // [R12]
    start   = 1'b0;
    tdata   = 8'h00;
    rdat    = 8'h00;
    push    = 1'b0;
    pop     = 1'b0;
    done    = 1'b0;
    pexp    = 1'b0;
    acc     = avs_read || avs_write;
    // a write to a full holding register stalls until it drains
    if (avs_write && avs_address == REG_TXDATA && st_ff.hold_v)
      acc = 1'b0;

    // bus: waitrequest drops for one cycle, read data formed with it
    nxt_st.wait_r = 1'b1;
    if (acc && st_ff.wait_r)
    begin
      nxt_st.wait_r = 1'b0;
      case (avs_address)
        REG_CTRL:   nxt_st.rdata = 32'(st_ff.ctrl);
        REG_STATUS: nxt_st.rdata = {21'h000000, dsr, cts,
                      st_ff.xoff_sent, st_ff.paused, st_ff.ovr,
                      st_ff.ferr, st_ff.perr, st_ff.tst != FR_IDLE,
                      st_ff.hold_v, full, st_ff.cnt != '0};
        REG_RXDATA: nxt_st.rdata = {23'h000000, st_ff.cnt != '0,
                                    st_ff.rbuf[st_ff.rp]};
        default:    nxt_st.rdata = 32'h00000000;
      endcase
    end
    if (acc && !st_ff.wait_r)
    begin
      if (avs_write && avs_address == REG_CTRL)
        nxt_st.ctrl = (st_ff.ctrl & ~bmask[CTRL_W-1:0])
                    | (avs_writedata[CTRL_W-1:0] & bmask[CTRL_W-1:0]);
      if (avs_write && avs_address == REG_TXDATA && avs_byteenable[0])
      begin
        nxt_st.hold_v = 1'b1;
        nxt_st.hold_d = avs_writedata[7:0];
      end
      if (avs_write && avs_address == REG_CMD && avs_byteenable[0]
          && avs_writedata[CMD_CLR])
      begin
        nxt_st.perr = 1'b0;
        nxt_st.ferr = 1'b0;
        nxt_st.ovr  = 1'b0;
      end
      if (avs_read && avs_address == REG_RXDATA && st_ff.cnt != '0)
        pop = 1'b1;
    end

    // transmitter: pacing characters first, then echo, then host data
    if (tick && st_ff.tst == FR_IDLE && !st_ff.ctrl[CF_BRK] && !hw_hold)
    begin
      if (st_ff.send_xoff)
      begin
        start = 1'b1;
        tdata = CHAR_XOFF;
        nxt_st.send_xoff = 1'b0;
      end
      else if (st_ff.send_xon)
      begin
        start = 1'b1;
        tdata = CHAR_XON;
        nxt_st.send_xon = 1'b0;
      end
      else if (st_ff.echo_v)
      begin
        start = 1'b1;
        tdata = st_ff.echo_d;
        nxt_st.echo_v = 1'b0;
      end
      else if (st_ff.hold_v && !st_ff.paused)  // [R5]
      begin
        start = 1'b1;
        tdata = st_ff.hold_d;
        nxt_st.hold_v = 1'b0;
      end
    end
    if (start)
    begin
      if (!word8)
        tdata[7] = 1'b0;  // [R2]
      case (par)
        PAR_ODD:  nxt_st.tpar = ~(^tdata);
        PAR_EVEN: nxt_st.tpar = ^tdata;
        PAR_ONE:  nxt_st.tpar = 1'b1;  // [R19]
        default:  nxt_st.tpar = 1'b0;  // [R19]
      endcase
      nxt_st.tst  = FR_START;
      nxt_st.tsh  = tdata;
      nxt_st.tdiv = 4'h0;
      nxt_st.tbit = 3'h0;
      nxt_st.line = 1'b0;  // [R18]
    end
    else if (tick && st_ff.tst != FR_IDLE)
    begin
      nxt_st.tdiv = st_ff.tdiv + 4'h1;
      if (st_ff.tdiv == 4'hF)
      begin
        case (st_ff.tst)
          FR_START:
          begin
            nxt_st.tst  = FR_DATA;
            nxt_st.line = st_ff.tsh[0];  // [R18]
            nxt_st.tsh  = st_ff.tsh >> 1;
          end
          FR_DATA:
          begin
            if (st_ff.tbit == (word8 ? 3'h7 : 3'h6))  // [R2]
            begin
              nxt_st.tst   = (par == PAR_NONE) ? FR_STOP : FR_PAR;
              nxt_st.line  = (par == PAR_NONE) ? 1'b1 : st_ff.tpar;  // [R4]
              nxt_st.tstop = 1'b0;
            end
            else
            begin
              nxt_st.tbit = st_ff.tbit + 3'h1;
              nxt_st.line = st_ff.tsh[0];
              nxt_st.tsh  = st_ff.tsh >> 1;
            end
          end
          FR_PAR:
          begin
            nxt_st.tst  = FR_STOP;
            nxt_st.line = 1'b1;
          end
          FR_STOP:
          begin
            if (stop2 && !st_ff.tstop)  // [R3]
              nxt_st.tstop = 1'b1;
            else
              nxt_st.tst = FR_IDLE;
          end
          default: nxt_st.tst = FR_IDLE;
        endcase
      end
    end
    // outside pin: idle high in loop-back, low while breaking
    nxt_st.txd = st_ff.ctrl[CF_LOOP] ? 1'b1
               : (st_ff.ctrl[CF_BRK] ? 1'b0 : st_ff.line);  // [R16] [R15]

    // receiver: centre on start bit, then sample every sixteen ticks
    if (tick)
    begin
      nxt_st.rdiv = st_ff.rdiv + 4'h1;
      case (st_ff.rst)
        FR_IDLE:
        begin
          nxt_st.rdiv = 4'h0;
          if (!rx_in)
            nxt_st.rst = FR_START;
        end
        FR_START:
        begin
          if (st_ff.rdiv == 4'h7)
          begin
            nxt_st.rdiv = 4'h0;
            nxt_st.rbit = 3'h0;
            nxt_st.rst  = rx_in ? FR_IDLE : FR_DATA;
          end
        end
        FR_DATA:
        begin
          if (st_ff.rdiv == 4'hF)
          begin
            nxt_st.rsh  = {rx_in, st_ff.rsh[7:1]};  // [R18]
            nxt_st.rbit = st_ff.rbit + 3'h1;
            if (st_ff.rbit == (word8 ? 3'h7 : 3'h6))
              nxt_st.rst = (par == PAR_NONE) ? FR_STOP : FR_PAR;
          end
        end
        FR_PAR:
        begin
          if (st_ff.rdiv == 4'hF)
          begin
            nxt_st.rpar = rx_in;
            nxt_st.rst  = FR_STOP;
          end
        end
        FR_STOP:
        begin
          if (st_ff.rdiv == 4'hF)
          begin
            done = 1'b1;
            nxt_st.rst = FR_IDLE;
            if (!rx_in)
              nxt_st.ferr = 1'b1;
          end
        end
        default: nxt_st.rst = FR_IDLE;
      endcase
    end
    if (done)
    begin
      rdat = word8 ? st_ff.rsh : {1'b0, st_ff.rsh[7:1]};
      case (par)
        PAR_ODD:  pexp = ~(^rdat);
        PAR_EVEN: pexp = ^rdat;
        PAR_ONE:  pexp = 1'b1;
        default:  pexp = 1'b0;
      endcase
      if (par != PAR_NONE && pexp != st_ff.rpar)
        nxt_st.perr = 1'b1;
      if (st_ff.ctrl[CF_TXXON] && rdat == CHAR_XOFF)  // [R5]
        nxt_st.paused = 1'b1;
      else if (st_ff.ctrl[CF_TXXON] && rdat == CHAR_XON)
        nxt_st.paused = 1'b0;
      else
      begin
        if (full && !pop)
          nxt_st.ovr = 1'b1;
        else
          push = 1'b1;
        if (st_ff.ctrl[CF_ECHO] && !nxt_st.echo_v)  // [R14]
        begin
          nxt_st.echo_v = 1'b1;
          nxt_st.echo_d = rdat;
        end
      end
    end
    if (!st_ff.ctrl[CF_TXXON])
      nxt_st.paused = 1'b0;

    // receive buffer pointers
    if (push)
    begin
      nxt_st.rbuf[st_ff.wp] = rdat;
      nxt_st.wp = st_ff.wp + AW'(1);
    end
    if (pop)
      nxt_st.rp = st_ff.rp + AW'(1);
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);

    // receive pacing: xoff near full, xon once drained
    if (st_ff.ctrl[CF_RXXON])  // [R6]
    begin
      if (st_ff.cnt >= (AW+1)'(RX_DEPTH - 2) && !st_ff.xoff_sent)
      begin
        nxt_st.send_xoff = 1'b1;
        nxt_st.xoff_sent = 1'b1;
      end
      else if (st_ff.xoff_sent && st_ff.cnt == '0 && !st_ff.send_xoff)
      begin
        nxt_st.send_xon  = 1'b1;
        nxt_st.xoff_sent = 1'b0;
      end
    end

    // modem lines
    case (rts_m)
      HS_ON:   nxt_st.rts = 1'b1;   // [R7]
      HS_ROOM: nxt_st.rts = !full;  // [R8]
      default: nxt_st.rts = 1'b0;   // [R7]
    endcase
    case (dtr_m)
      HS_ON:   nxt_st.dtr = 1'b1;   // [R10]
      HS_ROOM: nxt_st.dtr = !full;  // [R11]
      default: nxt_st.dtr = 1'b0;   // [R10] [R13]
    endcase

    // port reset discards both directions and returns to idle
    if (acc && !st_ff.wait_r && avs_write && avs_address == REG_CMD
        && avs_byteenable[0] && avs_writedata[CMD_FLUSH])  // [R17]
    begin
      nxt_st.tst       = FR_IDLE;
      nxt_st.line      = 1'b1;
      nxt_st.hold_v    = 1'b0;
      nxt_st.echo_v    = 1'b0;
      nxt_st.send_xon  = 1'b0;
      nxt_st.send_xoff = 1'b0;
      nxt_st.xoff_sent = 1'b0;
      nxt_st.paused    = 1'b0;
      nxt_st.rst       = FR_IDLE;
      nxt_st.wp        = '0;
      nxt_st.rp        = '0;
      nxt_st.cnt       = '0;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_ff        <= '0;
      st_ff.ctrl   <= CTRL_RESET;  // [R1]
      st_ff.wait_r <= 1'b1;
      st_ff.line   <= 1'b1;
      st_ff.txd    <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  assign avs_readdata    = st_ff.rdata;
  assign avs_waitrequest = st_ff.wait_r;
  assign txd             = st_ff.txd;
  assign rts             = st_ff.rts;
  assign dtr             = st_ff.dtr;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_rts_fixed: assert property ( // [R7]
    (st_ff.ctrl[CF_RTS +: 2] == HS_ON) |=> rts)
    else $error("rts not high in on mode");
  a_rts_room: assert property ( // [R8]
    (st_ff.ctrl[CF_RTS +: 2] == HS_ROOM)
    |=> (rts == (st_ff.cnt != (AW+1)'(RX_DEPTH)) || $changed(st_ff.cnt)))
    else $error("rts does not follow buffer room");
  a_dtr_rs422: assert property ( // [R13]
    st_ff.ctrl[CF_RS422] |=> !dtr)
    else $error("dtr driven while rs422 selected");
  a_cts_hold: assert property ( // [R9]
    (st_ff.tst == FR_IDLE && st_ff.ctrl[CF_RTS +: 2] == HS_ROOM && !cts)
    |=> st_ff.tst == FR_IDLE)
    else $error("frame started while cts low");
  a_forced_one: assert property ( // [R19]
    (st_ff.tst == FR_PAR && st_ff.ctrl[CF_PAR +: 3] == PAR_ONE)
    |-> st_ff.line)
    else $error("forced-one parity bit not high");
  a_break_low: assert property ( // [R16]
    (st_ff.ctrl[CF_BRK] && !st_ff.ctrl[CF_LOOP])[*2] |=> !txd)
    else $error("break not driven on txd");
  a_start_low: assert property ( // [R18]
    (st_ff.tst == FR_IDLE ##1 st_ff.tst == FR_START) |-> !st_ff.line)
    else $error("start bit not low");
  a_flush_empty: assert property ( // [R17]
    (avs_write && !avs_waitrequest && avs_address == REG_CMD
     && avs_byteenable[0] && avs_writedata[CMD_FLUSH])
    |=> (st_ff.cnt == '0 && !st_ff.hold_v && st_ff.tst == FR_IDLE))
    else $error("port reset left buffered data");
endmodule

/* File: include/spf_pkg.sv */
package spf_pkg;
  // clock and bit timing
  localparam int CLK_HZ     = 40_000_000;
  localparam int OVERSAMPLE = 16;
  localparam int NUM_BAUD   = 17;

  // register byte offsets
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_TXDATA = 5'h04;
  localparam logic [4:0] REG_STATUS = 5'h08;
  localparam logic [4:0] REG_RXDATA = 5'h0C;
  localparam logic [4:0] REG_CMD    = 5'h10;

  // control field positions
  localparam int CF_BAUD  = 0;
  localparam int CF_WORD8 = 5;
  localparam int CF_STOP2 = 6;
  localparam int CF_PAR   = 7;
  localparam int CF_TXXON = 10;
  localparam int CF_RXXON = 11;
  localparam int CF_RTS   = 12;
  localparam int CF_DTR   = 14;
  localparam int CF_RS422 = 16;
  localparam int CF_ECHO  = 17;
  localparam int CF_LOOP  = 18;
  localparam int CF_BRK   = 19;
  localparam int CTRL_W   = 20;
  // 9600 baud, eight bits, one stop, no parity, all pacing off
  localparam logic [19:0] CTRL_RESET = 20'h0002C;

  // command bits
  localparam int CMD_FLUSH = 0;
  localparam int CMD_CLR   = 1;

  // software pacing characters
  localparam logic [7:0] CHAR_XON  = 8'h11;
  localparam logic [7:0] CHAR_XOFF = 8'h13;

  typedef enum logic [2:0] {
    PAR_NONE = 3'b000, PAR_ODD = 3'b001, PAR_EVEN = 3'b010,
    PAR_ZERO = 3'b011, PAR_ONE = 3'b100
  } spf_par_t;

  typedef enum logic [1:0] {
    HS_OFF = 2'b00, HS_ON = 2'b01, HS_ROOM = 2'b10
  } spf_hs_t;

  typedef enum logic [2:0] {
    FR_IDLE = 3'b000, FR_START = 3'b001, FR_DATA = 3'b010,
    FR_PAR  = 3'b011, FR_STOP  = 3'b100
  } spf_fr_t;

  // divider terminal count for one oversample tick of the chosen rate
  function automatic logic [15:0] spf_div(input logic [4:0] sel,
                                          input int clk_hz);
    int b;
    case (sel)
      5'h00: b = 50;
      5'h01: b = 75;
      5'h02: b = 110;
      5'h03: b = 150;
      5'h04: b = 300;
      5'h05: b = 1200;
      5'h06: b = 1800;
      5'h07: b = 2000;
      5'h08: b = 2400;
      5'h09: b = 3600;
      5'h0A: b = 4800;
      5'h0B: b = 7200;
      5'h0D: b = 19200;
      5'h0E: b = 38400;
      5'h0F: b = 57600;
      5'h10: b = 115200;
      default: b = 9600;
    endcase
    return 16'((clk_hz + (OVERSAMPLE / 2) * b) / (OVERSAMPLE * b) - 1);
  endfunction
endpackage

/* File: verilog/spf_baud.sv */
`timescale 1ns/10ps
module spf_baud #(
  parameter int CLK_HZ = spf_pkg::CLK_HZ
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // rate select and oversample enable
  input  wire logic [4:0] sel,
  output logic            tick
);
  import spf_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } spf_bd_t;

  spf_bd_t st_ff;
  spf_bd_t nxt_st;

  // programmable divider, one-cycle enable per oversample slot
  always_comb
  begin
    nxt_st = st_ff;
    if (st_ff.cnt >= spf_div(sel, CLK_HZ))  // [R20] [R1]
    begin
      nxt_st.cnt  = 16'h0000;
      nxt_st.tick = 1'b1;
    end
    else
    begin
      nxt_st.cnt  = st_ff.cnt + 16'h0001;
      nxt_st.tick = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign tick = st_ff.tick;
endmodule

/* File: sim/spf_host.sv */
`timescale 1ns/10ps
module spf_host (
  // clock
  input  wire logic clk,
  // serial and handshake lines
  input  wire logic txd,
  output logic      rxd,
  output logic      cts,
  output logic      dsr
);
  logic [11:0] frame;
  int          nfr;
  int          bt;

  // idle line, remote ready to accept
  initial
  begin
    rxd = 1'b1;
    cts = 1'b1;
    dsr = 1'b1;
    bt = 160;
    nfr = 0;
  end

  // sample each txd frame mid-bit, start bit first
  always
  begin
    @(negedge txd);
    repeat (bt / 2) @(posedge clk);
    for (int i = 0; i < 12; i++)
    begin
      frame[i] = txd;
      repeat (bt) @(posedge clk);
    end
    nfr++;
  end

  // send the first nb bits of a frame, bit 0 first
  task automatic frm(input logic [11:0] f, input int nb);
    for (int i = 0; i < nb; i++)
    begin
      rxd <= f[i];
      repeat (bt) @(posedge clk);
    end
  endtask

  // send one character: start, data lsb first, one stop
  task automatic send(input logic [7:0] c);
    frm({3'b111, c, 1'b0}, 10);
  endtask
endmodule

/* File: sim/test_serial_port_flow_control.sv */
`timescale 1ns/10ps
module test_serial_port_flow_control;
  import spf_pkg::*;
  localparam int HZ  = 1_600_000;
  localparam int DEP = 4;
  localparam int BD  = 16 * ((HZ + 8 * 9600) / (16 * 9600));
  localparam int BF  = 16 * ((HZ + 8 * 115200) / (16 * 115200));

  logic        clk;
  logic        rstn;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rxd;
  logic        txd;
  logic        cts;
  logic        dsr;
  logic        rts;
  logic        dtr;
  int          err_total;
  int          num_checks;

  spf_top #(.CLK_HZ(HZ), .RX_DEPTH(DEP)) DUT (
    .clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rxd(rxd), .txd(txd), .cts(cts), .dsr(dsr), .rts(rts), .dtr(dtr)
  );

  spf_host host (.clk(clk), .txd(txd), .rxd(rxd), .cts(cts), .dsr(dsr));

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic results();
    if (err_total == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 9000);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      err_total++;
      results();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // control word at the fast rate
  task automatic cfg(input logic [31:0] v);
    wr(REG_CTRL, v | 32'h10);
    host.bt = BF;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // bounded wait for a txd level, n counts the edges
  task automatic wait_txd(input logic v, output int n);
    n = 0;
    while (txd !== v && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000)
    begin
      err_total++;
      results();
    end
  endtask

  // bounded wait for the host to hold k frames
  task automatic wait_fr(input int k);
    int n;
    n = 0;
    while (host.nfr < k && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    if (host.nfr < k)
    begin
      err_total++;
      results();
    end
  endtask

  // poll for a received character, then pop and compare it
  task automatic rx_get(input logic [7:0] c);
    logic [31:0] q;
    int n;
    n = 0;
    q = 0;
    while (q[0] !== 1'b1 && n < 400)
    begin
      bus(1'b0, REG_STATUS, 0, q);
      n++;
    end
    if (q[0] !== 1'b1)
    begin
      err_total++;
      results();
    end
    bus(1'b0, REG_RXDATA, 0, q);
    check(q, {23'h0, 1'b1, c});
  endtask

  // reset values and default bit time
  task automatic t_reset();
    logic [31:0] q;
    int a, b;
    bus(1'b0, REG_CTRL, 0, q);
    check(q, 32'h0002C);
    check(32'({rts, dtr}), 32'h0);
    wr(REG_TXDATA, 32'h55);
    wait_txd(1'b0, a);
    wait_txd(1'b1, b);
    check(32'(b), 32'(BD));
    wait_fr(1);
    check(32'(host.frame[9:0]), {22'h0, 1'b1, 8'h55, 1'b0});
  endtask

  // every parity mode, then seven bits with two stops
  task automatic t_frames();
    logic [7:0] c;
    logic       p;
    int         a, b, k;
    c = 8'hA7;
    for (int m = 1; m < 5; m++)
    begin
      cfg(32'h20 | (32'(m) << CF_PAR));
      p = (m == 1) ? ~^c : (m == 2) ? ^c : (m == 4);
      k = host.nfr;
      wr(REG_TXDATA, {24'h0, c});
      wait_fr(k + 1);
      check(32'(host.frame[10:0]), {21'h0, 1'b1, p, c, 1'b0});
    end
    cfg(32'h40);
    wr(REG_TXDATA, 32'h7F);
    wr(REG_TXDATA, 32'h7F);
    wait_txd(1'b1, a);
    wait_txd(1'b0, b);
    check(32'(b >= 9 * BF && b < 10 * BF), 32'h1);
    tick(300);
  endtask

  // receive with echo off, then on
  task automatic t_rx();
    int k;
    cfg(32'h20);
    k = host.nfr;
    host.send(8'h3C);
    rx_get(8'h3C);
    tick(250);
    check(32'(host.nfr), 32'(k));
    cfg(32'h20 | 32'h1 << CF_ECHO);
    host.send(8'hC3);
    wait_fr(k + 1);
    check(32'(host.frame[9:0]), {22'h0, 1'b1, 8'hC3, 1'b0});
    rx_get(8'hC3);
  endtask

  // one parity frame received: p is the parity bit, e the error expected
  task automatic rx_par(input int m, input logic p, input logic e);
    logic [31:0] q;
    cfg(32'h20 | (32'(m) << CF_PAR));
    host.frm({2'b11, p, 8'h3C, 1'b0}, 11);
    rx_get(8'h3C);
    bus(1'b0, REG_STATUS, 0, q);
    check(32'(q[4]), 32'(e));
    wr(REG_CMD, 32'h2);
  endtask

  // receive side parity in every mode, then a seven-bit character
  task automatic t_rxpar();
    rx_par(4, 1'b0, 1'b1);
    rx_par(2, 1'b0, 1'b0);
    rx_par(1, 1'b0, 1'b1);
    rx_par(3, 1'b1, 1'b1);
    cfg(32'h0);
    host.frm({4'hF, 7'h55, 1'b0}, 9);
    rx_get(8'h55);
  endtask

  // static lines, rs422, buffer room, receive pacing, flush
  task automatic t_hs();
    logic [31:0] q;
    int k;
    cfg(32'h20 | 32'h5 << CF_RTS);
    tick(2);
    check(32'({rts, dtr}), 32'h3);
    cfg(32'h20 | 32'h5 << CF_RTS | 32'h1 << CF_RS422);
    tick(2);
    check(32'({rts, dtr}), 32'h2);
    cfg(32'h20 | 32'hA << CF_RTS | 32'h1 << CF_RXXON);
    tick(2);
    check(32'({rts, dtr}), 32'h3);
    k = host.nfr;
    repeat (DEP) host.send(8'h41);
    wait_fr(k + 1);
    check(32'(host.frame[8:1]), 32'(CHAR_XOFF));
    tick(4);
    check(32'({rts, dtr}), 32'h0);
    wr(REG_CMD, 32'h1);
    bus(1'b0, REG_STATUS, 0, q);
    check(32'(q[0]), 32'h0);
    tick(2);
    check(32'({rts, dtr}), 32'h3);
  endtask

  // transmit held by cts, dsr, then received xoff
  task automatic t_hold();
    int k;
    for (int m = 0; m < 3; m++)
    begin
      cfg(32'h20 | 32'hA << CF_RTS | 32'h1 << CF_TXXON);
      if (m == 0) host.cts <= 1'b0;
      if (m == 1) host.dsr <= 1'b0;
      if (m == 2) host.send(CHAR_XOFF);
      k = host.nfr;
      wr(REG_TXDATA, 32'h96);
      tick(300);
      check(32'(host.nfr), 32'(k));
      host.cts <= 1'b1;
      host.dsr <= 1'b1;
      if (m == 2) host.send(CHAR_XON);
      wait_fr(k + 1);
      check(32'(host.frame[8:1]), 32'h96);
    end
  endtask

  // loop-back keeps txd idle, then a break holds it low
  task automatic t_misc();
    int k;
    k = host.nfr;
    cfg(32'h20 | 32'h1 << CF_LOOP);
    wr(REG_TXDATA, 32'h5A);
    rx_get(8'h5A);
    tick(250);
    check(32'(host.nfr), 32'(k));
    cfg(32'h20 | 32'h1 << CF_BRK);
    tick(400);
    check(32'(txd), 32'h0);
  endtask

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // reset, then the scenarios
  initial
  begin
    err_total = 0;
    num_checks = 0;
    rstn = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_frames();
    t_rx();
    t_rxpar();
    t_hs();
    t_hold();
    t_misc();
    results();
  end
endmodule
